// File: rtl/tfu_pkg.sv
// Constants and types shared by the upper task-file register block
package tfu_pkg;

  localparam logic [3:0] OFS_CYL_HIGH = 4'h5;
  localparam logic [3:0] OFS_DRIVE_HEAD = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;
  localparam logic [3:0] OFS_ALT_STATUS = 4'hE;
  localparam logic [3:0] OFS_DEV_CTRL = 4'hE;
  localparam logic [3:0] OFS_DRIVE_ADDR = 4'hF;

  localparam int DEVCTL_SOFT_RESET_POS = 2;
  localparam int DEVCTL_INT_DISABLE_POS = 1;

  localparam logic [7:0] CYL_HIGH_RST = 8'h00;
  localparam logic [7:0] DRIVE_HEAD_RST = 8'hA0;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] READ_DATA_RST = 8'h00;

  typedef struct packed {
    logic compatOne7;
    logic blockAddressingSelect;
    logic compatOne5;
    logic cardSelect;
    logic [3:0] head;
  } tfu_drive_head_t;

  typedef struct packed {
    logic busy;
    logic ready;
    logic writeFaultFlag;
    logic seekCompleteFlag;
    logic dataRequestFlag;
    logic correctedErrorFlag;
    logic indexFlag;
    logic error;
  } tfu_status_t;

  typedef struct packed {
    logic unknown7;
    logic writeActiveN;
    logic [3:0] invertedHead;
    logic drive1SelectedN;
    logic drive0SelectedN;
  } tfu_drive_addr_t;

  typedef struct packed {
    logic csN;
    logic rdN;
    logic wrN;
    logic [3:0] addr;
    logic [7:0] data;
  } tfu_host_pins_t;

  localparam logic [14:0] HOST_PINS_RST = 15'h7_000;

endpackage

// File: rtl/tfu_pin_sync.sv
// Three-stage pin synchroniser with agreement qualifier
`timescale 1ns/1ps
`default_nettype none
module tfu_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] stable
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] stable_ff;
  logic [WIDTH-1:0] nxt_stable;

  // A bit moves only once stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      nxt_stable[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i] : stable_ff[i];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
      stage3_ff <= RESET_VAL;
      stable_ff <= RESET_VAL;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      stable_ff <= nxt_stable;
    end
  end

  assign stable = stable_ff;
endmodule // tfu_pin_sync
`default_nettype wire

// File: rtl/tfu_int_ctrl.sv
// Interrupt pending flag and enable gating
`timescale 1ns/1ps
`default_nettype none
module tfu_int_ctrl (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic irqEvent,
  input wire logic statusReadDone,
  input wire logic softReset,
  input wire logic interruptDisableN,
  output logic intReq,
  output logic pending
);
  logic pending_ff;
  logic intReq_ff;
  logic nxt_pending;
  logic nxt_intReq;

  always_comb begin
    nxt_pending = pending_ff;
    if (statusReadDone || softReset) begin
      nxt_pending = 1'b0;
    end
    // A new event in the clearing cycle is kept
    if (irqEvent) begin
      nxt_pending = 1'b1;
    end
    nxt_intReq = nxt_pending & ~interruptDisableN;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending_ff <= 1'b0;
      intReq_ff <= 1'b0;
    end else begin
      pending_ff <= nxt_pending;
      intReq_ff <= nxt_intReq;
    end
  end

  assign intReq = intReq_ff;
  assign pending = pending_ff;
endmodule // tfu_int_ctrl
`default_nettype wire

// File: rtl/tfu_task_file_upper.sv
// Upper task-file registers: cylinder high, drive/head, status, control, drive address
`timescale 1ns/1ps
`default_nettype none
module tfu_task_file_upper
  import tfu_pkg::*;
#(
  parameter bit SUPPORT_CARD1 = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hostCs_n,
  input wire logic hostRd_n,
  input wire logic hostWr_n,
  input wire logic [3:0] hostAddr,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOe_n,
  input wire logic [7:0] sectorNumber,
  input wire logic [7:0] cylinderLow,
  input wire logic coreBusy,
  input wire logic coreReady,
  input wire logic coreWriteFault,
  input wire logic coreSeekDone,
  input wire logic coreDataReq,
  input wire logic coreCorrected,
  input wire logic coreError,
  input wire logic coreWriteActive,
  input wire logic coreIrqEvent,
  input wire logic coreDmaWant,
  input wire logic cardBusMode,
  input wire logic copyFieldCard,
  input wire logic ideCardNumber,
  input wire logic errAddrLoad,
  input wire logic [27:0] errAddress,
  output logic [27:0] blockAddress,
  output logic blockAddrMode,
  output logic [3:0] headNumber,
  output logic [7:0] cylinderHigh,
  output logic cardSelected,
  output logic softReset,
  output logic intReq,
  output logic configIntEnable,
  output logic dmaReq
);

  function automatic logic isMapped(input logic [3:0] addr);
    isMapped = (addr == OFS_CYL_HIGH) || (addr == OFS_DRIVE_HEAD) || (addr == OFS_STATUS) ||
               (addr == OFS_ALT_STATUS) || (addr == OFS_DRIVE_ADDR);
  endfunction

  // An access counts once, on the edge where its strobe is seen to end
  function automatic logic endsAt(input logic done, input logic [3:0] at, input logic [3:0] addr);
    endsAt = done && (at == addr);
  endfunction

  // Selected bits read low only for a card that is addressed and ready
  function automatic logic driveSelN(input logic sel, input logic card, input logic ready);
    driveSelN = ~(sel & card & ready);
  endfunction

  // Host pins
  tfu_host_pins_t pinsRaw;
  tfu_host_pins_t pins;
  logic [14:0] pinsStable;

  assign pinsRaw = '{
    csN: hostCs_n,
    rdN: hostRd_n,
    wrN: hostWr_n,
    addr: hostAddr,
    data: hostDataIn
  };

  // Every access pays about four cycles here; the host has no wait signal to hold it off
  tfu_pin_sync #(
    .WIDTH(15),
    .RESET_VAL(HOST_PINS_RST)
  ) tfu_pin_sync_inst (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinIn(pinsRaw),
    .stable(pinsStable)
  );

  assign pins = pinsStable;

  logic rdActive;
  logic wrActive;
  assign rdActive = ~pins.csN & ~pins.rdN;
  assign wrActive = ~pins.csN & ~pins.wrN;

  // Register state
  logic [7:0] cylHigh_ff;
  tfu_drive_head_t driveHead_ff;
  logic softResetBit_ff;
  logic interruptDisableN_ff;
  logic rdPrev_ff;
  logic wrPrev_ff;
  logic [3:0] rdAddr_ff;
  logic [3:0] wrAddr_ff;
  logic [7:0] wrData_ff;

  logic [7:0] nxt_cylHigh;
  tfu_drive_head_t nxt_driveHead;
  logic nxt_softResetBit;
  logic nxt_interruptDisableN;
  logic [3:0] nxt_rdAddr;
  logic [3:0] nxt_wrAddr;
  logic [7:0] nxt_wrData;
  logic writeDone;
  logic statusReadDone;
  // Strobe history for end-of-access detection
  logic nxt_rdPrev;
  logic nxt_wrPrev;

  always_comb begin
    nxt_cylHigh = cylHigh_ff;
    nxt_driveHead = driveHead_ff;
    nxt_softResetBit = softResetBit_ff;
    nxt_interruptDisableN = interruptDisableN_ff;
    nxt_rdAddr = rdActive ? pins.addr : rdAddr_ff;
    nxt_wrAddr = wrActive ? pins.addr : wrAddr_ff;
    nxt_wrData = wrActive ? pins.data : wrData_ff;
    // Reset level matches the idle strobe, so no false end follows reset
    nxt_rdPrev = rdActive;
    nxt_wrPrev = wrActive;
    // A write takes effect when the strobe goes away, with the last data seen
    writeDone = wrPrev_ff & ~wrActive;
    statusReadDone = endsAt(rdPrev_ff & ~rdActive, rdAddr_ff, OFS_STATUS);
    // Failing sector address left for the host; busy keeps the host out here
    if (errAddrLoad) begin
      nxt_cylHigh = errAddress[23:16];
      nxt_driveHead.head = errAddress[27:24];
    end else if (writeDone && !coreBusy) begin
      if (wrAddr_ff == OFS_CYL_HIGH) begin
        nxt_cylHigh = wrData_ff;
      end
      if (wrAddr_ff == OFS_DRIVE_HEAD) begin
        // Bits 7 and 5 kept as written; nothing here depends on them
        nxt_driveHead = wrData_ff;
      end
    end
    // Control register stays writable even while busy
    if (endsAt(writeDone, wrAddr_ff, OFS_DEV_CTRL)) begin
      // Only the two live bits are kept
      nxt_softResetBit = wrData_ff[DEVCTL_SOFT_RESET_POS];
      nxt_interruptDisableN = wrData_ff[DEVCTL_INT_DISABLE_POS];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cylHigh_ff <= CYL_HIGH_RST;
      driveHead_ff <= DRIVE_HEAD_RST;
      softResetBit_ff <= 1'b0;
      interruptDisableN_ff <= 1'b0;
      rdPrev_ff <= 1'b0;
      wrPrev_ff <= 1'b0;
      rdAddr_ff <= 4'h0;
      wrAddr_ff <= 4'h0;
      wrData_ff <= 8'h00;
    end else begin
      cylHigh_ff <= nxt_cylHigh;
      driveHead_ff <= nxt_driveHead;
      softResetBit_ff <= nxt_softResetBit;
      interruptDisableN_ff <= nxt_interruptDisableN;
      rdPrev_ff <= nxt_rdPrev;
      wrPrev_ff <= nxt_wrPrev;
      rdAddr_ff <= nxt_rdAddr;
      wrAddr_ff <= nxt_wrAddr;
      wrData_ff <= nxt_wrData;
    end
  end

  // Card number and selection
  logic ownCard;
  logic thisSelected;
  always_comb begin
    // Card-bus modes take the number from the copy field, if card 1 is supported
    if (cardBusMode) begin
      ownCard = SUPPORT_CARD1 ? copyFieldCard : 1'b0;
    end else begin
      ownCard = ideCardNumber;
    end
    thisSelected = (driveHead_ff.cardSelect == ownCard);
  end

  // Status and derived outputs
  tfu_status_t nxt_status;
  tfu_status_t status_ff;
  tfu_drive_addr_t driveAddr;
  logic [27:0] nxt_blockAddress;
  logic nxt_dmaReq;
  logic [7:0] nxt_readData;
  logic nxt_dataOe_n;
  logic [7:0] readData_ff;
  logic dataOe_n_ff;
  logic [27:0] blockAddress_ff;
  logic [3:0] headNumber_ff;
  logic blockAddrMode_ff;
  logic cardSelected_ff;
  logic dmaReq_ff;
  logic configIntEnable_ff;
  // Output mirrors
  logic [3:0] nxt_headNumber;
  logic nxt_blockAddrMode;
  logic nxt_cardSelected;
  logic nxt_configIntEnable;

  always_comb begin
    nxt_status.busy = coreBusy;
    // Ready follows the core from power-up and stays low through soft reset
    nxt_status.ready = coreReady & ~softResetBit_ff;
    nxt_status.writeFaultFlag = coreWriteFault;
    nxt_status.seekCompleteFlag = coreSeekDone;
    nxt_status.dataRequestFlag = coreDataReq;
    // Sticks with the status only; never stops a running read
    nxt_status.correctedErrorFlag = coreCorrected;
    nxt_status.indexFlag = 1'b0;
    nxt_status.error = coreError;

    driveAddr.unknown7 = 1'b0;
    driveAddr.writeActiveN = ~coreWriteActive;
    driveAddr.invertedHead = ~driveHead_ff.head;
    driveAddr.drive1SelectedN = driveSelN(thisSelected, ownCard, coreReady);
    driveAddr.drive0SelectedN = driveSelN(thisSelected, ~ownCard, coreReady);

    nxt_blockAddress = {driveHead_ff.head, cylHigh_ff, cylinderLow, sectorNumber};

    // Gated by the status being loaded, so the request never outlives the bits that allow it
    nxt_dmaReq = coreDmaWant & (nxt_status.busy | nxt_status.dataRequestFlag);

    // Mirrors for the core side, registered so every output leaves a flop
    nxt_headNumber = driveHead_ff.head;
    nxt_blockAddrMode = driveHead_ff.blockAddressingSelect;
    nxt_cardSelected = thisSelected;
    nxt_configIntEnable = ~interruptDisableN_ff;

    case (pins.addr)
      OFS_CYL_HIGH: nxt_readData = cylHigh_ff;
      OFS_DRIVE_HEAD: nxt_readData = driveHead_ff;
      OFS_STATUS: nxt_readData = status_ff;
      OFS_ALT_STATUS: nxt_readData = status_ff;
      OFS_DRIVE_ADDR: nxt_readData = driveAddr;
      default: nxt_readData = READ_DATA_RST;
    endcase
    if (!rdActive) begin
      nxt_readData = readData_ff;
    end
    // Offsets held by other blocks are left undriven
    nxt_dataOe_n = ~(rdActive & isMapped(pins.addr));
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= STATUS_RST;
      readData_ff <= READ_DATA_RST;
      dataOe_n_ff <= 1'b1;
      blockAddress_ff <= 28'h000_0000;
      headNumber_ff <= 4'h0;
      blockAddrMode_ff <= 1'b0;
      cardSelected_ff <= 1'b0;
      dmaReq_ff <= 1'b0;
      configIntEnable_ff <= 1'b1;
    end else begin
      status_ff <= nxt_status;
      readData_ff <= nxt_readData;
      dataOe_n_ff <= nxt_dataOe_n;
      blockAddress_ff <= nxt_blockAddress;
      headNumber_ff <= nxt_headNumber;
      blockAddrMode_ff <= nxt_blockAddrMode;
      cardSelected_ff <= nxt_cardSelected;
      dmaReq_ff <= nxt_dmaReq;
      configIntEnable_ff <= nxt_configIntEnable;
    end
  end

  // Pending flag lives on its own so set-over-clear priority sits in one place
  tfu_int_ctrl tfu_int_ctrl_inst (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .irqEvent(coreIrqEvent),
    .statusReadDone(statusReadDone),
    .softReset(softResetBit_ff),
    .interruptDisableN(interruptDisableN_ff),
    .intReq(intReq),
    .pending()
  );

  assign hostDataOut = readData_ff;
  assign hostDataOe_n = dataOe_n_ff;
  assign blockAddress = blockAddress_ff;
  assign blockAddrMode = blockAddrMode_ff;
  assign headNumber = headNumber_ff;
  assign cylinderHigh = cylHigh_ff;
  assign cardSelected = cardSelected_ff;
  assign softReset = softResetBit_ff;
  assign configIntEnable = configIntEnable_ff;
  assign dmaReq = dmaReq_ff;

endmodule // tfu_task_file_upper
`default_nettype wire

// File: tb/tfu_task_file_upper_props.sv
// Assertion checker for the upper task-file registers
`timescale 1ns/1ps
`default_nettype none
module tfu_task_file_upper_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hostCs_n,
  input wire logic hostRd_n,
  input wire logic hostWr_n,
  input wire logic hostDataOe_n,
  input wire logic [7:0] sectorNumber,
  input wire logic [7:0] cylinderLow,
  input wire logic coreBusy,
  input wire logic coreDataReq,
  input wire logic coreIrqEvent,
  input wire logic errAddrLoad,
  input wire logic [27:0] errAddress,
  input wire logic [27:0] blockAddress,
  input wire logic [3:0] headNumber,
  input wire logic [7:0] cylinderHigh,
  input wire logic softReset,
  input wire logic intReq,
  input wire logic configIntEnable,
  input wire logic dmaReq
);
  logic [3:0] wrAge_ff;
  logic [3:0] nxt_wrAge;
  logic [3:0] rdAge_ff;
  logic [3:0] nxt_rdAge;
  logic [7:0] errHigh;
  // Strobes cross a synchroniser, so effects are tied to a bounded age instead
  always_comb begin
    nxt_wrAge = (!hostCs_n && !hostWr_n) ? 4'h0 : wrAge_ff + {3'h0, wrAge_ff != 4'hF};
    nxt_rdAge = (!hostCs_n && !hostRd_n) ? 4'h0 : rdAge_ff + {3'h0, rdAge_ff != 4'hF};
    errHigh = errAddress[23:16];
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrAge_ff <= 4'hF;
      rdAge_ff <= 4'hF;
    end else begin
      wrAge_ff <= nxt_wrAge;
      rdAge_ff <= nxt_rdAge;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence quietFile;
    ($stable(headNumber) && $stable(cylinderHigh) && $stable(cylinderLow) && $stable(sectorNumber)) [*3];
  endsequence
  sequence irqArmed;
    coreIrqEvent && !softReset ##1 !softReset ##1 configIntEnable;
  endsequence
  AST_BLOCK_ADDR: assert property (quietFile |-> blockAddress == {headNumber, cylinderHigh, cylinderLow, sectorNumber})
    else $error("block address differs from task file");
  AST_DMA_GATE: assert property (dmaReq |-> $past(coreBusy) || $past(coreDataReq))
    else $error("dma request without busy or data request");
  AST_INT_MASK: assert property (intReq |-> configIntEnable)
    else $error("interrupt raised while disabled");
  AST_IRQ_SET: assert property (irqArmed |-> intReq)
    else $error("interrupt event not raised");
  AST_ERR_LOAD: assert property (errAddrLoad |=> cylinderHigh == $past(errHigh))
    else $error("failing address not loaded");
  AST_CYL_WRITE: assert property (!$stable(cylinderHigh) |-> $past(errAddrLoad) || (wrAge_ff <= 4'h9 && !$past(coreBusy)))
    else $error("cylinder high changed without a permitted write");
  AST_SRST_HOLD: assert property (!$stable(softReset) |-> wrAge_ff <= 4'h9)
    else $error("soft reset changed without a host write");
  AST_SRST_CLR: assert property (softReset [*3] |-> !intReq)
    else $error("interrupt survives soft reset");
  AST_OE_READ: assert property (!hostDataOe_n |-> rdAge_ff <= 4'h9)
    else $error("data driven without a read");
endmodule // tfu_task_file_upper_props
bind tfu_task_file_upper tfu_task_file_upper_props tfu_task_file_upper_props_inst (
  .core_clk, .arst_n, .hostCs_n, .hostRd_n, .hostWr_n, .hostDataOe_n, .sectorNumber, .cylinderLow,
  .coreBusy, .coreDataReq, .coreIrqEvent, .errAddrLoad, .errAddress, .blockAddress, .headNumber,
  .cylinderHigh, .softReset, .intReq, .configIntEnable, .dmaReq);
`default_nettype wire

// File: tb/tfu_host_model.sv
// Host-side model driving the task-file strobes
`timescale 1ns/1ps
`default_nettype none
module tfu_host_model
  import tfu_pkg::*;
(
  input wire logic core_clk,
  output logic hostCs_n,
  output logic hostRd_n,
  output logic hostWr_n,
  output logic [3:0] hostAddr,
  output logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOe_n
);
  initial begin
    hostCs_n = 1'b1;
    hostRd_n = 1'b1;
    hostWr_n = 1'b1;
    hostAddr = 4'h0;
    hostDataIn = 8'h00;
  end
  // Strobe held 7 cycles, gap 6: the pins are synchronised, no handshake exists
  task automatic busCycle(input logic [3:0] a, input logic [7:0] d, input logic wr,
                          output logic [7:0] q, output logic oeSeen);
    @(posedge core_clk);
    #1;
    hostAddr = a;
    hostDataIn = d;
    hostCs_n = 1'b0;
    hostRd_n = wr;
    hostWr_n = !wr;
    oeSeen = 1'b0;
    // Outputs are looked at just after each edge, once they have settled
    repeat (7) begin
      @(posedge core_clk);
      #1;
      oeSeen = oeSeen | (hostDataOe_n === 1'b0);
    end
    q = hostDataOut;
    hostCs_n = 1'b1;
    hostRd_n = 1'b1;
    hostWr_n = 1'b1;
    hostAddr = ~a;
    hostDataIn = ~d;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  task automatic busWrite(input logic [3:0] a, input logic [7:0] d, input logic raw);
    logic [7:0] q;
    logic s;
    if (!raw && a == OFS_DRIVE_HEAD) d = d | 8'hA0;
    if (!raw && a == OFS_DEV_CTRL) d = d & 8'h06;
    busCycle(a, d, 1'b1, q, s);
  endtask
endmodule // tfu_host_model
`default_nettype wire

// File: tb/test_ata_task_file_upper_regs.sv
// Self-checking bench for the upper task-file registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module test_ata_task_file_upper_regs
  import tfu_pkg::*;
;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hostCs_n, hostRd_n, hostWr_n, hostDataOe_n, blockAddrMode, cardSelected, softReset, intReq;
  logic configIntEnable, dmaReq, s;
  logic [3:0] hostAddr, headNumber;
  logic [7:0] hostDataIn, hostDataOut, cylinderHigh, q, expData;
  logic [27:0] blockAddress;
  logic [7:0] sectorNumber = 8'h00;
  logic [7:0] cylinderLow = 8'h00;
  logic coreWriteActive = 1'b0;
  logic coreIrqEvent = 1'b0;
  logic coreDmaWant = 1'b0;
  logic cardBusMode = 1'b0;
  logic copyFieldCard = 1'b0;
  logic ideCardNumber = 1'b0;
  logic errAddrLoad = 1'b0;
  logic [27:0] errAddress = 28'h000_0000;
  tfu_status_t st = 8'h00;
  tfu_status_t ex;
  tfu_drive_head_t dh;
  logic [31:0] rs = 32'h0000_DE90;
  logic [7:0] expQ[$];
  int err_total = 0;
  int compares = 0;
  always #2 core_clk = ~core_clk;
  tfu_host_model tfu_host_model_inst (.core_clk, .hostCs_n, .hostRd_n, .hostWr_n, .hostAddr, .hostDataIn,
    .hostDataOut, .hostDataOe_n);
  tfu_task_file_upper tfu_task_file_upper_inst (.core_clk, .arst_n, .hostCs_n, .hostRd_n, .hostWr_n, .hostAddr,
    .hostDataIn, .hostDataOut, .hostDataOe_n, .sectorNumber, .cylinderLow, .coreBusy(st.busy),
    .coreReady(st.ready), .coreWriteFault(st.writeFaultFlag), .coreSeekDone(st.seekCompleteFlag),
    .coreDataReq(st.dataRequestFlag), .coreCorrected(st.correctedErrorFlag), .coreError(st.error),
    .coreWriteActive, .coreIrqEvent, .coreDmaWant, .cardBusMode, .copyFieldCard, .ideCardNumber, .errAddrLoad,
    .errAddress, .blockAddress, .blockAddrMode, .headNumber, .cylinderHigh, .cardSelected, .softReset, .intReq,
    .configIntEnable, .dmaReq);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expQ.push_back(e);
    tfu_host_model_inst.busCycle(a, 8'h00, 1'b0, q, s);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    tfu_host_model_inst.busWrite(a, d, 1'b0);
  endtask
  task automatic pulse();
    coreIrqEvent = 1'b1;
    tick(1);
    coreIrqEvent = 1'b0;
    tick(3);
  endtask
  // A read result is checked when the data enable is withdrawn
  always @(posedge hostDataOe_n) begin
    if (arst_n && expQ.size() > 0) begin
      expData = expQ.pop_front();
      `CHK(hostDataOut, expData)
    end
  end
  task automatic results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    results();
  end
  initial begin
    tick(5);
    arst_n = 1'b1;
    rd(OFS_CYL_HIGH, CYL_HIGH_RST);
    rd(OFS_DRIVE_HEAD, DRIVE_HEAD_RST);
    rd(OFS_STATUS, STATUS_RST);
    rd(OFS_DRIVE_ADDR, 8'h7F);
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      st = rs[7:0];
      ex = st;
      ex.indexFlag = 1'b0;
      rd(OFS_STATUS, ex);
      rd(OFS_ALT_STATUS, ex);
    end
    st = 8'h50;
    for (int i = 0; i < 3; i++) begin
      rs = xs(rs);
      {sectorNumber, cylinderLow} = rs[15:0];
      dh = rs[23:16] | 8'hA0;
      dh.cardSelect = 1'b0;
      coreWriteActive = rs[i];
      wr(OFS_CYL_HIGH, rs[31:24]);
      wr(OFS_DRIVE_HEAD, dh);
      rd(OFS_CYL_HIGH, rs[31:24]);
      rd(OFS_DRIVE_HEAD, dh);
      `CHK(blockAddress, ({dh.head, rs[31:24], cylinderLow, sectorNumber}))
      `CHK(blockAddrMode, dh.blockAddressingSelect)
      `CHK(headNumber, dh.head)
      `CHK(cylinderHigh, rs[31:24])
      `CHK(cardSelected, 1'b1)
      rd(OFS_DRIVE_ADDR, {1'b0, !coreWriteActive, ~dh.head, 2'b10});
    end
    dh.cardSelect = 1'b1;
    wr(OFS_DRIVE_HEAD, dh);
    for (int i = 0; i < 8; i++) begin
      {cardBusMode, copyFieldCard, ideCardNumber} = i[2:0];
      tick(4);
      `CHK(cardSelected, cardBusMode ? copyFieldCard : ideCardNumber)
      rd(OFS_DRIVE_ADDR, {1'b0, !coreWriteActive, ~dh.head, !(cardBusMode ? copyFieldCard : ideCardNumber), 1'b1});
    end
    rs = xs(rs);
    errAddress = rs[27:0];
    errAddrLoad = 1'b1;
    tick(1);
    errAddrLoad = 1'b0;
    rd(OFS_CYL_HIGH, errAddress[23:16]);
    `CHK(headNumber, errAddress[27:24])
    st.busy = 1'b1;
    wr(OFS_CYL_HIGH, ~errAddress[23:16]);
    wr(OFS_DEV_CTRL, 8'h02);
    rd(OFS_CYL_HIGH, errAddress[23:16]);
    `CHK(configIntEnable, 1'b0)
    pulse();
    `CHK(intReq, 1'b0)
    st.busy = 1'b0;
    wr(OFS_DRIVE_ADDR, 8'h00);
    rd(OFS_DRIVE_ADDR, {1'b0, !coreWriteActive, ~errAddress[27:24], 2'b01});
    tfu_host_model_inst.busCycle(4'h3, 8'h00, 1'b0, q, s);
    `CHK(s, 1'b0)
    tfu_host_model_inst.busWrite(OFS_DEV_CTRL, 8'hF9, 1'b1);
    `CHK(configIntEnable, 1'b1)
    `CHK(softReset, 1'b0)
    pulse();
    `CHK(intReq, 1'b1)
    rd(OFS_ALT_STATUS, 8'h50);
    `CHK(intReq, 1'b1)
    rd(OFS_STATUS, 8'h50);
    tick(3);
    `CHK(intReq, 1'b0)
    wr(OFS_DEV_CTRL, 8'h00);
    pulse();
    wr(OFS_DEV_CTRL, 8'h06);
    tick(20);
    `CHK(softReset, 1'b1)
    `CHK(configIntEnable, 1'b0)
    rd(OFS_STATUS, 8'h10);
    wr(OFS_DEV_CTRL, 8'h00);
    `CHK(softReset, 1'b0)
    `CHK(intReq, 1'b0)
    coreDmaWant = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {st.dataRequestFlag, st.busy} = i[1:0];
      tick(4);
      `CHK(dmaReq, i != 0)
    end
    coreDmaWant = 1'b0;
    tick(4);
    `CHK(dmaReq, 1'b0)
    st = 8'h50;
    tick(8);
    `CHK(expQ.size(), 0)
    results();
  end
endmodule // test_ata_task_file_upper_regs
`default_nettype wire
